// ---- logic/pdr_defs.svh ----
// Offsets, field positions, reset values and the high-register mask of the PLL input divider
// and status register slice.
// Assumes it is included by bare name from the package and the design module.
`ifndef PDR_DEFS_SVH
`define PDR_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDR_ADDR_CKIN_HIGH 8'h2b
`define PDR_ADDR_CKIN_MID 8'h2c
`define PDR_ADDR_CKIN_LOW 8'h2d
`define PDR_ADDR_OSC_HIGH 8'h2e
`define PDR_ADDR_OSC_MID 8'h2f
`define PDR_ADDR_OSC_LOW 8'h30
`define PDR_ADDR_ACTIVE 8'h80
`define PDR_ADDR_LOSS 8'h81
`define PDR_ADDR_LOCK 8'h82
`define PDR_ADDR_LOSS_FLAGS 8'h83
`define PDR_ADDR_LOCK_FLAG 8'h84
`define PDR_ADDR_CONTROL 8'h88

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDR_BIT_CKIN_ACTIVE 0
`define PDR_BIT_OSC_ACTIVE 1
`define PDR_BIT_REF_LOSS 0
`define PDR_BIT_CKIN_LOSS 1
`define PDR_BIT_LOCK_LOSS 0
`define PDR_BIT_SKEW_PENDING 7
`define PDR_BIT_LOCK_FLAG 1
`define PDR_BIT_CAL_TRIGGER 6
`define PDR_HIGH_MASK 8'h07

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDR_RST_CKIN_PREDIV 19'h00009
`define PDR_RST_OSC_PREDIV 19'h00000
`define PDR_RST_ACTIVE 8'h20
`define PDR_RST_LOSS 8'h00
`define PDR_RST_LOCK 8'h01

`endif

// ---- logic/pdr_pkg.sv ----
// Types shared by the PLL input divider and status register slice.
// Assumes pdr_defs.svh sits on the include path.
`include "pdr_defs.svh"

package pdr_pkg;

	// Decoded register access from the host serial port engine.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdr_req_s;

	// Live alarm and selection state from the PLL core.
	typedef struct packed {
		logic ckin_selected;
		logic osc_selected;
		logic ckin_signal_loss_live;
		logic ref_signal_loss_live;
		logic lock_loss_live;
	} pdr_live_s;

	typedef logic [18:0] pdr_prediv_t;

endpackage : pdr_pkg

// ---- logic/pdr_regs.sv ----
// PLL input pre-divider settings and live/latched status registers.
// Assumes the host serial engine delivers one decoded access per cycle and the
// PLL core supplies live alarm levels synchronous to clk.
// Reset is synchronous and active high; every register here sits in the one clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.svh"

module pdr_regs (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Host register access.
	input wire pdr_pkg::pdr_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	// PLL core status.
	input wire pdr_pkg::pdr_live_s live,
	input wire logic coarse_skew_write,
	input wire logic coarse_skew_done,
	// Reference tick and divided output.
	input wire logic ref_tick,
	output logic osc_div_tick,
	// Applied divider settings and calibration start.
	output pdr_pkg::pdr_prediv_t ckin_prediv_applied,
	output pdr_pkg::pdr_prediv_t osc_prediv_applied,
	output logic self_calibration_trigger
);
	import pdr_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Staged pre-divider settings, the values that software reads back.
	pdr_prediv_t ckin_prediv_value;
	pdr_prediv_t osc_prediv_value;
	pdr_prediv_t next_ckin_prediv_value;
	pdr_prediv_t next_osc_prediv_value;

	// Settings in use by the PLL, and the calibration start pulse.
	pdr_prediv_t next_ckin_prediv_applied;
	pdr_prediv_t next_osc_prediv_applied;
	logic next_self_calibration_trigger;

	// Sampled status registers as the host sees them.
	logic [7:0] active_input_status;
	logic [7:0] signal_loss_status;
	logic [7:0] lock_skew_status;
	logic [7:0] next_active_input_status;
	logic [7:0] next_signal_loss_status;
	logic [7:0] next_lock_skew_status;

	// Coarse skew adjustment still being processed by the core.
	logic skew_adjust_pending;
	logic next_skew_adjust_pending;

	// Held alarm flags, cleared by the host writing zero.
	logic ckin_loss_latched;
	logic ref_loss_latched;
	logic lock_loss_latched;
	logic next_ckin_loss_latched;
	logic next_ref_loss_latched;
	logic next_lock_loss_latched;

	// Registered read answer.
	logic [7:0] next_rdata;
	logic next_rvalid;

	// Oscillator-path divider counter and its output pulse.
	pdr_prediv_t div_count;
	pdr_prediv_t next_div_count;
	logic next_osc_div_tick;

	// Write strobes, one per decoded writable offset.
	logic wr_ckin_high;
	logic wr_ckin_mid;
	logic wr_ckin_low;
	logic wr_osc_high;
	logic wr_osc_mid;
	logic wr_osc_low;
	logic wr_loss_flags;
	logic wr_lock_flag;
	logic wr_cal;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Only the writable offsets are decoded, so writes to status registers fall through untouched.
	// A read and a write may arrive together; they are handled independently.
	assign wr_ckin_high = req.wr && (req.addr == `PDR_ADDR_CKIN_HIGH);
	assign wr_ckin_mid = req.wr && (req.addr == `PDR_ADDR_CKIN_MID);
	assign wr_ckin_low = req.wr && (req.addr == `PDR_ADDR_CKIN_LOW);
	assign wr_osc_high = req.wr && (req.addr == `PDR_ADDR_OSC_HIGH);
	assign wr_osc_mid = req.wr && (req.addr == `PDR_ADDR_OSC_MID);
	assign wr_osc_low = req.wr && (req.addr == `PDR_ADDR_OSC_LOW);
	assign wr_loss_flags = req.wr && (req.addr == `PDR_ADDR_LOSS_FLAGS);
	assign wr_lock_flag = req.wr && (req.addr == `PDR_ADDR_LOCK_FLAG);
	assign wr_cal = req.wr && (req.addr == `PDR_ADDR_CONTROL) && req.wdata[`PDR_BIT_CAL_TRIGGER];

	// ----------------------------------------
	// Pre-divider settings
	// ----------------------------------------
	// Staged values are what software sees; applied values move only at calibration start.
	// High registers keep only wdata[2:0]; the reserved bits 7:3 are dropped on the way in.
	always_comb begin
		next_ckin_prediv_value = ckin_prediv_value;
		next_osc_prediv_value = osc_prediv_value;
		next_ckin_prediv_applied = ckin_prediv_applied;
		next_osc_prediv_applied = osc_prediv_applied;
		if (wr_ckin_high) begin
			next_ckin_prediv_value[18:16] = req.wdata[2:0];
		end
		if (wr_ckin_mid) begin
			next_ckin_prediv_value[15:8] = req.wdata;
		end
		if (wr_ckin_low) begin
			next_ckin_prediv_value[7:0] = req.wdata;
		end
		if (wr_osc_high) begin
			next_osc_prediv_value[18:16] = req.wdata[2:0];
		end
		if (wr_osc_mid) begin
			next_osc_prediv_value[15:8] = req.wdata;
		end
		if (wr_osc_low) begin
			next_osc_prediv_value[7:0] = req.wdata;
		end
		// A write in the same cycle as the trigger is not applied until the next calibration.
		if (wr_cal) begin
			next_ckin_prediv_applied = ckin_prediv_value;
			next_osc_prediv_applied = osc_prediv_value;
		end
		next_self_calibration_trigger = wr_cal;
	end

	// Register the settings; staged and applied both start from the reset values.
	// Starting them equal means the PLL runs on the reset ratios until the first calibration.
	always_ff @(posedge clk) begin
		if (srst) begin
			ckin_prediv_value <= `PDR_RST_CKIN_PREDIV;
			osc_prediv_value <= `PDR_RST_OSC_PREDIV;
			ckin_prediv_applied <= `PDR_RST_CKIN_PREDIV;
			osc_prediv_applied <= `PDR_RST_OSC_PREDIV;
			self_calibration_trigger <= 1'b0;
		end else begin
			ckin_prediv_value <= next_ckin_prediv_value;
			osc_prediv_value <= next_osc_prediv_value;
			ckin_prediv_applied <= next_ckin_prediv_applied;
			osc_prediv_applied <= next_osc_prediv_applied;
			self_calibration_trigger <= next_self_calibration_trigger;
		end
	end

	// ----------------------------------------
	// Oscillator-path divider
	// ----------------------------------------
	// Counting 0..value gives value plus one reference ticks per output tick.
	always_comb begin
		next_div_count = div_count;
		next_osc_div_tick = 1'b0;
		if (ref_tick) begin
			// Greater-or-equal ends the period at once when calibration lowers the setting below the count.
			if (div_count >= osc_prediv_applied) begin
				next_div_count = '0;
				next_osc_div_tick = 1'b1;
			end else begin
				next_div_count = div_count + 19'h00001;
			end
		end
	end

	// Register the count and the divided pulse, so the pulse leaves the block glitch free.
	always_ff @(posedge clk) begin
		if (srst) begin
			div_count <= '0;
			osc_div_tick <= 1'b0;
		end else begin
			div_count <= next_div_count;
			osc_div_tick <= next_osc_div_tick;
		end
	end

	// ----------------------------------------
	// Live status and latched flags
	// ----------------------------------------
	// Status is sampled once per cycle so a read sees one coherent snapshot, at the cost of one cycle of lag.
	// The constant bit 5 of the active-input register comes from its reset value.
	always_comb begin
		next_active_input_status = `PDR_RST_ACTIVE;
		next_active_input_status[`PDR_BIT_OSC_ACTIVE] = live.osc_selected;
		next_active_input_status[`PDR_BIT_CKIN_ACTIVE] = live.ckin_selected && !live.ckin_signal_loss_live;
		next_signal_loss_status = `PDR_RST_LOSS;
		next_signal_loss_status[`PDR_BIT_CKIN_LOSS] = live.ckin_signal_loss_live;
		next_signal_loss_status[`PDR_BIT_REF_LOSS] = live.ref_signal_loss_live;
		// A new skew write while done arrives keeps the pending bit set.
		next_skew_adjust_pending = skew_adjust_pending;
		if (coarse_skew_done) begin
			next_skew_adjust_pending = 1'b0;
		end
		if (coarse_skew_write) begin
			next_skew_adjust_pending = 1'b1;
		end
		// The pending bit uses the next value so a skew write shows in the same sample.
		next_lock_skew_status = 8'h00;
		next_lock_skew_status[`PDR_BIT_SKEW_PENDING] = next_skew_adjust_pending;
		next_lock_skew_status[`PDR_BIT_LOCK_LOSS] = live.lock_loss_live;
		// Writing 1 leaves a flag alone; an alarm in the clearing cycle wins.
		next_ckin_loss_latched = ckin_loss_latched;
		next_ref_loss_latched = ref_loss_latched;
		next_lock_loss_latched = lock_loss_latched;
		if (wr_loss_flags && !req.wdata[`PDR_BIT_CKIN_LOSS]) begin
			next_ckin_loss_latched = 1'b0;
		end
		if (wr_loss_flags && !req.wdata[`PDR_BIT_REF_LOSS]) begin
			next_ref_loss_latched = 1'b0;
		end
		if (wr_lock_flag && !req.wdata[`PDR_BIT_LOCK_FLAG]) begin
			next_lock_loss_latched = 1'b0;
		end
		if (live.ckin_signal_loss_live) begin
			next_ckin_loss_latched = 1'b1;
		end
		if (live.ref_signal_loss_live) begin
			next_ref_loss_latched = 1'b1;
		end
		if (live.lock_loss_live) begin
			next_lock_loss_latched = 1'b1;
		end
	end

	// Register status and flags. Flags reset clear; an alarm still live after reset sets
	// them again one cycle later.
	always_ff @(posedge clk) begin
		if (srst) begin
			active_input_status <= `PDR_RST_ACTIVE;
			signal_loss_status <= `PDR_RST_LOSS;
			lock_skew_status <= `PDR_RST_LOCK;
			skew_adjust_pending <= 1'b0;
			ckin_loss_latched <= 1'b0;
			ref_loss_latched <= 1'b0;
			lock_loss_latched <= 1'b0;
		end else begin
			active_input_status <= next_active_input_status;
			signal_loss_status <= next_signal_loss_status;
			lock_skew_status <= next_lock_skew_status;
			skew_adjust_pending <= next_skew_adjust_pending;
			ckin_loss_latched <= next_ckin_loss_latched;
			ref_loss_latched <= next_ref_loss_latched;
			lock_loss_latched <= next_lock_loss_latched;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped offsets and reserved bits read as zero.
	// The control register is not in the read map, so the calibration trigger reads back as zero.
	always_comb begin
		next_rdata = 8'h00;
		next_rvalid = req.rd;
		if (req.rd) begin
			case (req.addr)
				`PDR_ADDR_CKIN_HIGH: next_rdata = {5'h00, ckin_prediv_value[18:16]};
				`PDR_ADDR_CKIN_MID: next_rdata = ckin_prediv_value[15:8];
				`PDR_ADDR_CKIN_LOW: next_rdata = ckin_prediv_value[7:0];
				`PDR_ADDR_OSC_HIGH: next_rdata = {5'h00, osc_prediv_value[18:16]};
				`PDR_ADDR_OSC_MID: next_rdata = osc_prediv_value[15:8];
				`PDR_ADDR_OSC_LOW: next_rdata = osc_prediv_value[7:0];
				`PDR_ADDR_ACTIVE: next_rdata = active_input_status;
				`PDR_ADDR_LOSS: next_rdata = signal_loss_status;
				`PDR_ADDR_LOCK: next_rdata = lock_skew_status;
				`PDR_ADDR_LOSS_FLAGS: next_rdata = {6'h00, ckin_loss_latched, ref_loss_latched};
				`PDR_ADDR_LOCK_FLAG: next_rdata = {6'h00, lock_loss_latched, 1'b0};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Register the read answer so rdata rests at zero between reads and stands one cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

endmodule : pdr_regs
`default_nettype wire

// ---- dv/pdr_regs_checker.sv ----
// Assertions on the ports of the pre-divider and status register slice.
// Assumes a single clk domain with synchronous active high srst.
`timescale 1ns/1ps
`default_nettype none
module pdr_regs_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register access.
	input wire pdr_pkg::pdr_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	// Core side.
	input wire pdr_pkg::pdr_live_s live,
	input wire logic ref_tick,
	input wire logic osc_div_tick,
	input wire pdr_pkg::pdr_prediv_t ckin_prediv_applied,
	input wire pdr_pkg::pdr_prediv_t osc_prediv_applied,
	input wire logic self_calibration_trigger
);
	import pdr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Reads answer exactly one cycle later and data rests at zero otherwise.
	rd_answer_a: assert property (req.rd |=> rvalid) else $error("read not answered");
	rvalid_cause_a: assert property (rvalid |-> $past(req.rd)) else $error("stray read valid");
	rdata_idle_a: assert property (!rvalid |-> rdata == 8'h00) else $error("read data not idle");
	// Calibration start is the only moment applied settings may move.
	cal_start_a: assert property (
		req.wr && req.addr == 8'h88 && req.wdata[6] |=> self_calibration_trigger)
		else $error("calibration not started");
	trig_cause_a: assert property (
		self_calibration_trigger |-> $past(req.wr) && $past(req.addr) == 8'h88)
		else $error("stray calibration");
	applied_hold_a: assert property (
		!self_calibration_trigger |-> $stable(ckin_prediv_applied) && $stable(osc_prediv_applied))
		else $error("settings moved without calibration");
	// Divider output only follows a reference event; zero divides by one.
	div_cause_a: assert property (osc_div_tick |-> $past(ref_tick)) else $error("stray divided tick");
	div_one_a: assert property (ref_tick && osc_prediv_applied == '0 |=> osc_div_tick)
		else $error("divide by one missed");
	// Status reads show the live levels sampled one cycle before the read.
	loss_live_a: assert property (
		rvalid && $past(req.addr) == 8'h81 |-> rdata[1:0] ==
		{$past(live.ckin_signal_loss_live, 2), $past(live.ref_signal_loss_live, 2)})
		else $error("loss status wrong");
	lock_live_a: assert property (
		rvalid && $past(req.addr) == 8'h82 |-> rdata[0] == $past(live.lock_loss_live, 2))
		else $error("lock status wrong");
	cal_c: cover property (self_calibration_trigger);
	div_c: cover property (osc_div_tick && osc_prediv_applied != '0);
	read_c: cover property (rvalid && rdata != 8'h00);
endmodule : pdr_regs_checker
bind pdr_regs pdr_regs_checker chk (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
	.live(live), .ref_tick(ref_tick), .osc_div_tick(osc_div_tick), .ckin_prediv_applied(ckin_prediv_applied),
	.osc_prediv_applied(osc_prediv_applied), .self_calibration_trigger(self_calibration_trigger));
`default_nettype wire

// ---- dv/pdr_host_model.sv ----
// Host controller model issuing decoded register accesses.
// Assumes outputs change on the falling edge and the slice samples on the rising one.
`timescale 1ns/1ps
`default_nettype none
module pdr_host_model (
	// Clock.
	input wire logic clk,
	// Register access.
	output pdr_pkg::pdr_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	import pdr_pkg::*;
	initial req = '0;
	// Writes are how the host starts calibration and clears latched flags.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		req.wdata = ~d; // Released bus does not keep the last value.
	endtask : wr
	// Read waits a bounded time for the answer so a dead slice cannot hang.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge clk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'b0;
		req.addr = ~a;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (rvalid === 1'b1) begin
				d = rdata;
				ok = 1'b1;
			end else begin
				@(negedge clk);
			end
		end
	endtask : rd
endmodule : pdr_host_model
`default_nettype wire

// ---- dv/pdr_regs_tb_top.sv ----
// Self-checking bench for the pre-divider and status register slice.
// Assumes the checker is bound in and the host model drives the access port.
`timescale 1ns/1ps
`default_nettype none
module pdr_regs_tb_top;
	import pdr_pkg::*;
	logic clk, srst, rvalid, skw, skd, ref_tick, osc_div_tick, trig, ok;
	pdr_req_s req;
	pdr_live_s live;
	logic [7:0] rdata, d;
	pdr_prediv_t ckin_app, osc_app;
	int n_mismatch = 0;
	int total_checks = 0;
	pdr_regs dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid), .live(live),
		.coarse_skew_write(skw), .coarse_skew_done(skd), .ref_tick(ref_tick), .osc_div_tick(osc_div_tick),
		.ckin_prediv_applied(ckin_app), .osc_prediv_applied(osc_app), .self_calibration_trigger(trig));
	pdr_host_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	// Free running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// Read one register and compare; a missing answer ends the run.
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d, ok);
		if (!ok) begin
			n_mismatch++;
			$display("[FAIL] %0t no read answer", $time);
			print_verdict();
		end
		check({11'h000, d}, {11'h000, e});
	endtask : rc
	task automatic t_reset();
		logic [7:0] a[9] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h80, 8'h81, 8'h82};
		logic [7:0] e[9] = '{8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h01};
		for (int i = 0; i < 9; i++) rc(a[i], e[i]);
		$display("reset values done");
	endtask : t_reset
	// All ones shows the reserved high bits dropping; status writes must not stick.
	task automatic t_prediv();
		for (int i = 0; i < 6; i++) host.wr(8'h2b + 8'(i), 8'hff);
		for (int i = 0; i < 6; i++) rc(8'h2b + 8'(i), (i % 3 == 0) ? 8'h07 : 8'hff);
		host.wr(8'h80, 8'hff);
		host.wr(8'h82, 8'h80);
		rc(8'h80, 8'h20);
		rc(8'h82, 8'h01);
		$display("pre-divider access done");
	endtask : t_prediv
	task automatic t_cal();
		logic [7:0] v[6] = '{8'h05, 8'h3c, 8'h96, 8'h00, 8'h00, 8'h02};
		for (int i = 0; i < 6; i++) host.wr(8'h2b + 8'(i), v[i]);
		check(ckin_app, 19'h00009);
		check(osc_app, 19'h00000);
		check({18'h00000, trig}, 19'h00000);
		host.wr(8'h88, 8'h40);
		check({18'h00000, trig}, 19'h00001);
		check(ckin_app, 19'h53c96);
		check(osc_app, 19'h00002);
		@(negedge clk);
		check({18'h00000, trig}, 19'h00000);
		rc(8'h88, 8'h00);
		$display("calibration done");
	endtask : t_cal
	// Nine back to back events through divide by three give three outputs.
	task automatic t_div();
		int n = 0;
		for (int i = 0; i < 12; i++) begin
			@(negedge clk);
			ref_tick = (i < 9);
			if (osc_div_tick === 1'b1) n++;
		end
		check(19'(n), 19'd3);
		// Zero is divide by one: four back to back events give four outputs.
		for (int i = 0; i < 3; i++) host.wr(8'h2e + 8'(i), 8'h00);
		host.wr(8'h88, 8'h40);
		check(osc_app, 19'h00000);
		n = 0;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			ref_tick = (i < 4);
			if (osc_div_tick === 1'b1) n++;
		end
		check(19'(n), 19'd4);
		$display("divider done");
	endtask : t_div
	task automatic t_status();
		logic [4:0] p[4] = '{5'b10000, 5'b10100, 5'b01010, 5'b01001};
		logic [23:0] e[4] = '{24'h210000, 24'h200200, 24'h220100, 24'h220001};
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			live = p[i];
			repeat (2) @(negedge clk);
			rc(8'h80, e[i][23:16]);
			rc(8'h81, e[i][15:8]);
			rc(8'h82, e[i][7:0]);
		end
		$display("live status done");
	endtask : t_status
	task automatic t_skew();
		@(negedge clk);
		skw = 1'b1;
		@(negedge clk);
		skw = 1'b0;
		rc(8'h82, 8'h81);
		@(negedge clk);
		skd = 1'b1;
		@(negedge clk);
		skd = 1'b0;
		rc(8'h82, 8'h01);
		$display("skew pending done");
	endtask : t_skew
	// Flags outlive the alarms; writing one, or zero while the alarm is live, must not clear them.
	task automatic t_latch();
		host.wr(8'h84, 8'h00);
		rc(8'h84, 8'h02);
		@(negedge clk);
		live = '0;
		host.wr(8'h83, 8'h03);
		rc(8'h83, 8'h03);
		rc(8'h84, 8'h02);
		host.wr(8'h83, 8'h00);
		host.wr(8'h84, 8'h00);
		rc(8'h83, 8'h00);
		rc(8'h84, 8'h00);
		$display("latched flags done");
	endtask : t_latch
	// Main sequence: reset for 20 cycles, then every scenario in turn.
	initial begin
		srst = 1'b1;
		live = 5'b00001;
		skw = 1'b0;
		skd = 1'b0;
		ref_tick = 1'b0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		t_reset();
		t_prediv();
		t_cal();
		t_div();
		t_status();
		t_skew();
		t_latch();
		print_verdict();
	end
endmodule : pdr_regs_tb_top
`default_nettype wire
